// >>> bench/lds_host_model.sv
`timescale 1ns/1ps
module lds_host_model (
	output logic ser_clk_o,
	output logic ser_data_o
);
	// Clock and data rest high between words.
	initial begin
		ser_clk_o = 1'b1;
		ser_data_o = 1'b1;
	end
	// Sends n clock cycles of a word, B0 first, at 125 ns per cycle.
	task automatic send_word(input logic [11:0] w, input int n);
		#3; // Keeps serial edges off the core clock edges, as the two clocks are unrelated.
		for (int i = 0; i < n; i++) begin
			#62.5 ser_clk_o = 1'b0;
			#20 ser_data_o = (i < 12) ? w[i] : 1'b1;
			#42.5 ser_clk_o = 1'b1;
		end
	endtask
endmodule

// >>> bench/lds_serial_ctrl_properties.sv
`timescale 1ns/1ps
module lds_ctl_properties (
	input wire logic                   ref_clk_i,
	input wire logic                   reset_n_i,
	input wire logic                   ser_clk_i,
	input wire logic                   dev_reset_i,
	input wire logic                   boost_enable_ch1_i,
	input wire logic                   boost_enable_ch2_i,
	input wire logic                   drv_enable_ch1_o,
	input wire logic                   drv_enable_ch2_o,
	input wire lds_pkg::lds_level_type bias_level_ch1_o,
	input wire lds_pkg::lds_level_type bias_level_ch2_o,
	input wire logic                   boost_standby_ch1_o,
	input wire logic                   boost_standby_ch2_o,
	input wire logic                   boost_full_ch1_o,
	input wire logic                   boost_full_ch2_o
);
	import lds_pkg::*;
	logic       ser_q_r, ser_q_nxt;
	logic [3:0] since_r, since_nxt;
	// Counts core cycles since a rising serial clock edge, saturating at 15.
	always_comb begin
		ser_q_nxt = ser_clk_i;
		since_nxt = (ser_clk_i && !ser_q_r) ? 4'h0 : since_r + {3'h0, since_r != 4'hf};
	end
	// Registers the edge detector and counter.
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ser_q_r <= 1'b1;
			since_r <= 4'hf;
		end else begin
			ser_q_r <= ser_q_nxt;
			since_r <= since_nxt;
		end
	end
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	a_full_pin_one: assert property (boost_full_ch1_o |-> $past(boost_enable_ch1_i, 3))
		else $error("full boost on channel one with pin low");
	a_full_pin_two: assert property (boost_full_ch2_o |-> $past(boost_enable_ch2_i, 3))
		else $error("full boost on channel two with pin low");
	a_standby_pin_one: assert property (
		boost_standby_ch1_o |-> !$past(boost_enable_ch1_i, 3))
		else $error("standby boost on channel one with pin high");
	a_standby_pin_two: assert property (
		boost_standby_ch2_o |-> !$past(boost_enable_ch2_i, 3))
		else $error("standby boost on channel two with pin high");
	a_boost_mode_excl: assert property (!(boost_full_ch1_o && boost_standby_ch1_o))
		else $error("channel one boost both full and standby");
	a_boost_excl_two: assert property (!(boost_full_ch2_o && boost_standby_ch2_o))
		else $error("channel two boost both full and standby");
	a_pin_follow_one: assert property (
		(boost_full_ch1_o || boost_standby_ch1_o) && $past(boost_enable_ch1_i, 3)
		|-> boost_full_ch1_o)
		else $error("armed channel one ignores its pin");
	a_pin_follow_two: assert property (
		(boost_full_ch2_o || boost_standby_ch2_o) && $past(boost_enable_ch2_i, 3)
		|-> boost_full_ch2_o)
		else $error("armed channel two ignores its pin");
	a_dev_reset_clear: assert property (
		dev_reset_i |-> {drv_enable_ch1_o, drv_enable_ch2_o,
		bias_level_ch1_o, bias_level_ch2_o, boost_full_ch1_o, boost_full_ch2_o,
		boost_standby_ch1_o, boost_standby_ch2_o} == 14'h0000) else $error("reset left bits set");
	a_change_near_edge: assert property ($changed({drv_enable_ch1_o, drv_enable_ch2_o,
		bias_level_ch1_o, bias_level_ch2_o}) && !dev_reset_i |-> since_r < 4'ha)
		else $error("settings changed without a serial word");
endmodule
bind lds_serial_ctrl lds_ctl_properties CHK (.ref_clk_i, .reset_n_i, .ser_clk_i, .dev_reset_i,
	.boost_enable_ch1_i, .boost_enable_ch2_i, .drv_enable_ch1_o, .drv_enable_ch2_o,
	.bias_level_ch1_o, .bias_level_ch2_o, .boost_standby_ch1_o, .boost_standby_ch2_o,
	.boost_full_ch1_o, .boost_full_ch2_o);

// >>> bench/test_lds_serial_ctrl.sv
`timescale 1ns/1ps
module test_lds_serial_ctrl;
	import lds_pkg::*;
	logic          ref_clk_i, reset_n_i, dev_reset_i, boost_enable_ch1_i, boost_enable_ch2_i;
	logic          ser_clk_i, ser_data_i, drv_enable_ch1_o, drv_enable_ch2_o;
	logic          boost_standby_ch1_o, boost_standby_ch2_o, boost_full_ch1_o, boost_full_ch2_o;
	lds_level_type bias_level_ch1_o, bias_level_ch2_o;
	int            err_count, total_checks, cyc;
	lds_serial_ctrl DUT (.ref_clk_i, .reset_n_i, .ser_clk_i, .ser_data_i, .dev_reset_i,
		.boost_enable_ch1_i, .boost_enable_ch2_i, .drv_enable_ch1_o, .drv_enable_ch2_o,
		.bias_level_ch1_o, .bias_level_ch2_o, .boost_standby_ch1_o, .boost_standby_ch2_o,
		.boost_full_ch1_o, .boost_full_ch2_o);
	lds_host_model HOST (.ser_clk_o(ser_clk_i), .ser_data_o(ser_data_i));
	// Core clock at 20 MHz.
	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end
	// Cuts a hung run short.
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 4000) begin
			err_count++;
			end_of_test();
		end
	end
	// Builds a framed word with odd parity over B2..B10.
	function automatic lds_word_type mk(input logic c1, c2, drv, arm, input lds_level_type l);
		lds_word_type w;
		w = {1'b1, 1'b0, l[0], l[1], l[2], l[3], arm, drv, c2, c1, 1'b0, 1'b1};
		w[10] = ~^w[9:2];
		return w;
	endfunction
	task automatic chk(input string nm, input logic [9:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Compares drive, level and boost outputs against expectations.
	task automatic look(input logic [9:0] e, input logic [3:0] b);
		chk("drive_level", {drv_enable_ch1_o, drv_enable_ch2_o, bias_level_ch1_o,
			bias_level_ch2_o}, e);
		chk("boost", {6'h00, boost_full_ch1_o, boost_standby_ch1_o, boost_full_ch2_o,
			boost_standby_ch2_o}, {6'h00, b});
	endtask
	task automatic send(input lds_word_type w);
		HOST.send_word(w, 13);
		repeat (8) @(negedge ref_clk_i);
	endtask
	task automatic t_levels();
		send(mk(1'b0, 1'b1, 1'b1, 1'b0, 4'h5));
		for (int i = 0; i < 16; i++) begin
			send(mk(1'b1, 1'b0, i[0], 1'b0, i[3:0]));
			look({i[0], 1'b1, i[3:0], 4'h5}, 4'h0);
		end
	endtask
	task automatic t_boost();
		send(mk(1'b1, 1'b0, 1'b0, 1'b1, 4'h3));
		look({2'b01, 4'h3, 4'h5}, 4'b0100);
		@(negedge ref_clk_i);
		boost_enable_ch1_i = 1'b1;
		boost_enable_ch2_i = 1'b1;
		repeat (4) @(negedge ref_clk_i);
		look({2'b01, 4'h3, 4'h5}, 4'b1000);
		send(mk(1'b0, 1'b1, 1'b1, 1'b1, 4'h5));
		@(negedge ref_clk_i);
		boost_enable_ch1_i = 1'b0;
		repeat (4) @(negedge ref_clk_i);
		look({2'b01, 4'h3, 4'h5}, 4'b0110);
	endtask
	task automatic t_bad();
		lds_word_type m[5] = '{12'h001, 12'h002, 12'h400, 12'h800, 12'h00c};
		for (int k = 0; k < 5; k++) begin
			send(mk(1'b1, 1'b1, 1'b1, 1'b0, 4'ha) ^ m[k]);
			look({2'b01, 4'h3, 4'h5}, 4'b0110);
		end
		send(12'hfff);
		look(10'h000, 4'h0);
	endtask
	task automatic t_reset();
		send(mk(1'b1, 1'b1, 1'b1, 1'b1, 4'h9));
		look({2'b11, 4'h9, 4'h9}, 4'b0110);
		HOST.send_word(mk(1'b1, 1'b1, 1'b0, 1'b0, 4'h0), 6);
		@(negedge ref_clk_i);
		dev_reset_i = 1'b1;
		#10 look(10'h000, 4'h0);
		repeat (8) @(negedge ref_clk_i);
		dev_reset_i = 1'b0;
		send(mk(1'b1, 1'b0, 1'b1, 1'b0, 4'hc));
		look({2'b10, 4'hc, 4'h0}, 4'h0);
	endtask
	task automatic end_of_test();
		if (err_count == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Main sequence: undriven inputs are held low, then reset for 10 cycles.
	initial begin
		{reset_n_i, dev_reset_i, boost_enable_ch1_i, boost_enable_ch2_i} = 4'h0;
		repeat (10) @(negedge ref_clk_i);
		reset_n_i = 1'b1;
		look(10'h000, 4'h0);
		t_levels();
		t_boost();
		t_bad();
		t_reset();
		end_of_test();
	end
endmodule

// >>> core/lds_map.svh
`ifndef LDS_MAP_SVH
`define LDS_MAP_SVH

// ----------------------------------------------------------------
// Serial word layout and framing
// ----------------------------------------------------------------
`define LDS_BIT_START_HI  0
`define LDS_BIT_START_LO  1
`define LDS_BIT_SEL_CH1   2
`define LDS_BIT_SEL_CH2   3
`define LDS_SET_LSB       4
`define LDS_SET_MSB       9
`define LDS_BIT_PARITY    10
`define LDS_BIT_STOP      11
`define LDS_PAR_LSB       2
`define LDS_PAR_MSB       10

// ----------------------------------------------------------------
// Settings field layout (B4 at bit 0)
// ----------------------------------------------------------------
`define LDS_SET_DRV_EN    0
`define LDS_SET_BOOST_ARM 1
`define LDS_SET_LVL_D3    2
`define LDS_SET_LVL_D2    3
`define LDS_SET_LVL_D1    4
`define LDS_SET_LVL_D0    5

// ----------------------------------------------------------------
// Counts and reset values
// ----------------------------------------------------------------
`define LDS_LAST_EDGE     4'hc
`define LDS_CNT_STEP      4'h1
`define LDS_CNT_RST       4'h0
`define LDS_WORD_RST      12'h000
`define LDS_WORD_ONES     12'hfff
`define LDS_SET_RST       6'h00
`define LDS_LVL_RST       4'h0

`endif

// >>> core/lds_pkg.sv
package lds_pkg;
	typedef logic [11:0] lds_word_type;
	typedef logic [5:0]  lds_set_type;
	typedef logic [3:0]  lds_level_type;
	typedef logic [3:0]  lds_count_type;
endpackage

// >>> core/lds_serial_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - Undriven logic inputs count as low; pins are pulled down outside the core.
// - Each channel keeps its own settings; updating one leaves the other alone.
// - Each channel's bias level is one of 16 levels set by the word.
// - A boost enable pin does nothing unless that channel's boost is armed.
// - Armed with pin low gives only standby boost bias.
// - Full boost bias only while armed and that channel's pin is high.
// - Device reset is active high and asynchronous to the serial clock.
// - Reset clears every control bit of both channels at once, disabling both.
// - Reset clears the whole input shift register, dropping a partial word.
// - A word of twelve ones acts like reset, disabling both channels.
// - Data changes after falling edges; device samples on rising edges.
// - Twelve bits, B0 first, over 13 clock cycles; then clock and data idle high.
// - Start bits 1,0; channel selects; settings; odd parity B2..B10; stop 1.
// - B4 enables the driver, B5 arms boost; boosting needs B5 and pin high.
`include "lds_map.svh"

module lds_serial_ctrl (
	input  wire logic              ref_clk_i,
	input  wire logic              reset_n_i,
	input  wire logic              ser_clk_i,
	input  wire logic              ser_data_i,
	input  wire logic              dev_reset_i,
	input  wire logic              boost_enable_ch1_i,
	input  wire logic              boost_enable_ch2_i,
	output logic                   drv_enable_ch1_o,
	output logic                   drv_enable_ch2_o,
	output lds_pkg::lds_level_type bias_level_ch1_o,
	output lds_pkg::lds_level_type bias_level_ch2_o,
	output logic                   boost_standby_ch1_o,
	output logic                   boost_standby_ch2_o,
	output logic                   boost_full_ch1_o,
	output logic                   boost_full_ch2_o
);
	import lds_pkg::*;

	// ----------------------------------------------------------------
	// Reset trees
	// ----------------------------------------------------------------
	// Both domains clear at once on the device reset pin or the system reset.
	logic link_rst;
	logic ref_rst_n;
	assign link_rst  = dev_reset_i | ~reset_n_i;
	assign ref_rst_n = reset_n_i & ~dev_reset_i;

	// ----------------------------------------------------------------
	// Link domain: shift register and bit counter
	// ----------------------------------------------------------------
	lds_word_type  word_r;
	lds_word_type  word_nxt;
	lds_count_type cnt_r;
	lds_count_type cnt_nxt;
	logic          tgl_r;
	logic          tgl_nxt;
	logic          commit_load;
	logic          commit_clear;
	logic          frame_ok;
	logic          at_last;
	logic [1:0]    sel_ch;

	// Framing, stop and odd parity over B2..B10 decide whether a word is loaded; an all-ones word clears without passing them.
	assign frame_ok = word_r[`LDS_BIT_START_HI] & ~word_r[`LDS_BIT_START_LO]
		& word_r[`LDS_BIT_STOP]
		& (^word_r[`LDS_PAR_MSB:`LDS_PAR_LSB]);
	assign at_last      = (cnt_r == `LDS_LAST_EDGE);
	assign commit_clear = at_last & (word_r == `LDS_WORD_ONES);
	assign commit_load  = at_last & frame_ok;
	assign sel_ch       = {word_r[`LDS_BIT_SEL_CH2], word_r[`LDS_BIT_SEL_CH1]};

	// Twelve rising edges shift bits in B0 first; the thirteenth ends the word.
	always_comb begin
		word_nxt = word_r;
		cnt_nxt  = cnt_r;
		tgl_nxt  = tgl_r;
		if (at_last) begin
			cnt_nxt  = `LDS_CNT_RST;
			word_nxt = `LDS_WORD_RST;
			if (commit_load | commit_clear) begin
				tgl_nxt = ~tgl_r;  // Tells the reference domain new settings stand.
			end
		end else begin
			word_nxt = {ser_data_i, word_r[`LDS_BIT_STOP:`LDS_BIT_START_LO]};
			cnt_nxt  = cnt_r + `LDS_CNT_STEP;
		end
	end

	// Rising serial clock edges sample data; reset empties the shifter.
	always_ff @(posedge ser_clk_i or posedge link_rst) begin
		if (link_rst) begin
			word_r <= `LDS_WORD_RST;
			cnt_r  <= `LDS_CNT_RST;
			tgl_r  <= 1'b0;
		end else begin
			word_r <= word_nxt;
			cnt_r  <= cnt_nxt;
			tgl_r  <= tgl_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Reference domain: update toggle crossing
	// ----------------------------------------------------------------
	logic tgl_s1_r;
	logic tgl_s2_r;
	logic tgl_s3_r;
	logic tgl_s1_nxt;
	logic tgl_s2_nxt;
	logic tgl_s3_nxt;
	logic upd_pulse;

	// Two flops resynchronise the toggle; the third finds its edge.
	always_comb begin
		tgl_s1_nxt = tgl_r;
		tgl_s2_nxt = tgl_s1_r;
		tgl_s3_nxt = tgl_s2_r;
	end

	// The toggle chain clears with the rest of the reference domain.
	always_ff @(posedge ref_clk_i or negedge ref_rst_n) begin
		if (!ref_rst_n) begin
			tgl_s1_r <= 1'b0;
			tgl_s2_r <= 1'b0;
			tgl_s3_r <= 1'b0;
		end else begin
			tgl_s1_r <= tgl_s1_nxt;
			tgl_s2_r <= tgl_s2_nxt;
			tgl_s3_r <= tgl_s3_nxt;
		end
	end

	assign upd_pulse = tgl_s2_r ^ tgl_s3_r;

	// ----------------------------------------------------------------
	// Per-channel settings and outputs
	// ----------------------------------------------------------------
	logic          bst_pin [2];
	logic          drv_q   [2];
	lds_level_type lvl_q   [2];
	logic          stby_q  [2];
	logic          full_q  [2];

	// Pins are pulled down outside the core, so a floating pin arrives low.
	assign bst_pin[0] = boost_enable_ch1_i;
	assign bst_pin[1] = boost_enable_ch2_i;

	for (genvar ch = 0; ch < 2; ch++) begin : g_ch
		lds_set_type   set_r;
		lds_set_type   set_nxt;
		lds_set_type   cap_r;
		lds_set_type   cap_nxt;
		logic          bs1_r;
		logic          bs2_r;
		logic          drv_r;
		logic          drv_nxt;
		lds_level_type lvl_r;
		lds_level_type lvl_nxt;
		logic          stby_r;
		logic          stby_nxt;
		logic          full_r;
		logic          full_nxt;

		// A selected channel loads B4..B9; an all-ones word clears it.
		always_comb begin
			set_nxt = set_r;
			if (commit_clear) begin
				set_nxt = `LDS_SET_RST;
			end else if (commit_load && sel_ch[ch]) begin
				set_nxt = word_r[`LDS_SET_MSB:`LDS_SET_LSB];
			end
		end

		// Link-side settings hold still between words for the crossing.
		always_ff @(posedge ser_clk_i or posedge link_rst) begin
			if (link_rst) begin
				set_r <= `LDS_SET_RST;
			end else begin
				set_r <= set_nxt;
			end
		end

		// Captured settings and the decoded outputs of this channel.
		always_comb begin
			cap_nxt  = upd_pulse ? set_r : cap_r;
			drv_nxt  = cap_r[`LDS_SET_DRV_EN];
			lvl_nxt  = {cap_r[`LDS_SET_LVL_D3], cap_r[`LDS_SET_LVL_D2],
				cap_r[`LDS_SET_LVL_D1], cap_r[`LDS_SET_LVL_D0]};
			stby_nxt = cap_r[`LDS_SET_BOOST_ARM] & ~bs2_r;
			full_nxt = cap_r[`LDS_SET_BOOST_ARM] & bs2_r;
		end

		// Reference-side flops; reset drops every channel to disabled.
		always_ff @(posedge ref_clk_i or negedge ref_rst_n) begin
			if (!ref_rst_n) begin
				cap_r  <= `LDS_SET_RST;
				bs1_r  <= 1'b0;
				bs2_r  <= 1'b0;
				drv_r  <= 1'b0;
				lvl_r  <= `LDS_LVL_RST;
				stby_r <= 1'b0;
				full_r <= 1'b0;
			end else begin
				cap_r  <= cap_nxt;
				bs1_r  <= bst_pin[ch];
				bs2_r  <= bs1_r;
				drv_r  <= drv_nxt;
				lvl_r  <= lvl_nxt;
				stby_r <= stby_nxt;
				full_r <= full_nxt;
			end
		end

		assign drv_q[ch]  = drv_r;
		assign lvl_q[ch]  = lvl_r;
		assign stby_q[ch] = stby_r;
		assign full_q[ch] = full_r;
	end

	// ----------------------------------------------------------------
	// Output ports
	// ----------------------------------------------------------------
	// Each port is a channel flop taken straight out.
	assign drv_enable_ch1_o    = drv_q[0];
	assign drv_enable_ch2_o    = drv_q[1];
	assign bias_level_ch1_o    = lvl_q[0];
	assign bias_level_ch2_o    = lvl_q[1];
	assign boost_standby_ch1_o = stby_q[0];
	assign boost_standby_ch2_o = stby_q[1];
	assign boost_full_ch1_o    = full_q[0];
	assign boost_full_ch2_o    = full_q[1];

endmodule
